/* File: bmps_defs.vh */
/*
 Constants for the bit merge, population count and shift-add datapath:
 register word indices, command field positions, operation codes, flag
 and status bit positions. Assumes inclusion by bmps_core.v only.
*/
`ifndef BMPS_DEFS_VH
`define BMPS_DEFS_VH

// Register word indices (byte address = index * 4).
`define BMPS_IX_DATA0     6'h00
`define BMPS_IX_PTR0      6'h08
`define BMPS_IX_ACC_LO    6'h10
`define BMPS_IX_ACC_HI    6'h11
`define BMPS_IX_FLAGS     6'h12
`define BMPS_IX_CMD       6'h13
`define BMPS_IX_STAT      6'h14
`define BMPS_IX_MASK      6'h15

`define BMPS_NUM_DATA     8
`define BMPS_NUM_PTR      6
`define BMPS_ACC_W        40
`define BMPS_ACC_MSB      39

// Command word fields.
`define BMPS_CMD_OP       3:0
`define BMPS_CMD_DST      6:4
`define BMPS_CMD_SRCA     10:8
`define BMPS_CMD_SRCB     14:12
`define BMPS_CMD_SH2      16
`define BMPS_CMD_PAIR     17
`define BMPS_CMD_W        18

// Operation codes.
`define BMPS_OP_NOP       4'h0
`define BMPS_OP_MUX_RIGHT 4'h1
`define BMPS_OP_MUX_LEFT  4'h2
`define BMPS_OP_ONES      4'h3
`define BMPS_OP_ADDSH_D   4'h4
`define BMPS_OP_ADDSH_P   4'h5
`define BMPS_OP_SHADD_P   4'h6

// Arithmetic flag bits.
`define BMPS_FLAG_W       4
`define BMPS_FLAG_ZERO    0
`define BMPS_FLAG_NEG     1
`define BMPS_FLAG_RANGE   2
`define BMPS_FLAG_STICKY  3

// Event status bits.
`define BMPS_STAT_W       3
`define BMPS_STAT_DONE    0
`define BMPS_STAT_REFUSED 1
`define BMPS_STAT_OVF     2

`define BMPS_RES_W        36
`define BMPS_HALF_W       16
`define BMPS_SHIFT_ONE    2'h1
`define BMPS_SHIFT_TWO    2'h2

`endif

/* File: bmps_core.v */
/*
 Bit merge, ones count, add-then-shift and shift-then-add datapath with
 its own register file (eight data, six pointer, one 40-bit accumulator,
 arithmetic flags), reached as a classic Wishbone slave. A write to the
 command register with byte lane 0 selected issues one operation, executed on the next clock.
 Assumes one clock, a synchronous active-low reset and a Wishbone master
 that keeps the bus idle for at least one cycle after each acknowledge.
*/
// Behaviour
// - Right merge: accumulator takes source_1 then source_0 LSBs.
// - Left merge: accumulator takes source_0 then source_1 MSBs.
// - Merge writes back both source data registers.
// - Right merge: sources written back shifted right one.
// - Left merge: sources written back shifted left one.
// - Merge and count are long, may pair.
// - Count set bits into destination low half.
// - Count keeps source, updates no flags.
// - Add sources, shift left one or two, write.
// - Add-then-shift wraps, never saturates.
// - Data form updates zero and negative flags.
// - Data form sets range flag, sticky copy.
// - Pointer add-then-shift leaves flags unchanged.
// - Shift-then-add on pointers, no flags.
// - Short add/shift forms must never pair.
`timescale 1ns/1ps
`include "bmps_defs.vh"

module bmps_core (
   input  wire        clock,     // 200 MHz core clock
   input  wire        rst_n,     // synchronous reset, active low
   input  wire        wb_cyc_i,  // Wishbone cycle
   input  wire        wb_stb_i,  // Wishbone strobe
   input  wire        wb_we_i,   // Wishbone write enable
   input  wire [7:0]  wb_adr_i,  // byte address
   input  wire [3:0]  wb_sel_i,  // byte lane selects
   input  wire [31:0] wb_dat_i,  // write data
   output wire        wb_ack_o,  // acknowledge, one cycle
   output wire [31:0] wb_dat_o,  // read data
   output wire        irq_o      // level interrupt
);

   reg  [31:0]                 data_r [0:`BMPS_NUM_DATA-1];
   reg  [31:0]                 ptr_r  [0:`BMPS_NUM_PTR-1];
   reg  [`BMPS_ACC_MSB:0]      first_accumulator_r;
   reg  [`BMPS_FLAG_W-1:0]     flags_r;
   reg  [`BMPS_CMD_W-1:0]      cmd_r;
   reg                         go_r;
   reg  [`BMPS_STAT_W-1:0]     stat_r;
   reg  [`BMPS_STAT_W-1:0]     mask_r;
   reg                         ack_r;
   reg  [31:0]                 dat_r;
   reg                         irq_r;
   reg  [31:0]                 rd_nxt;
   reg  [`BMPS_ACC_MSB:0]      acc_nxt;
   reg                         acc_we;
   reg                         da_we;
   reg                         db_we;
   reg                         p_we;
   reg  [2:0]                  da_ix;
   reg  [2:0]                  db_ix;
   reg  [2:0]                  p_ix;
   reg  [31:0]                 da_val;
   reg  [31:0]                 db_val;
   reg  [31:0]                 p_val;
   reg  [`BMPS_FLAG_W-1:0]     flags_nxt;
   reg  [`BMPS_STAT_W-1:0]     ev_set;
   reg  [`BMPS_RES_W-1:0]      wide;
   integer                     i;

   wire                        bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire                        bus_wr  = bus_req & wb_we_i;
   wire [5:0]                  widx    = wb_adr_i[7:2];
   wire [3:0]                  op      = cmd_r[`BMPS_CMD_OP];
   wire [2:0]                  dst     = cmd_r[`BMPS_CMD_DST];
   wire [2:0]                  src_a   = cmd_r[`BMPS_CMD_SRCA];
   wire [2:0]                  src_b   = cmd_r[`BMPS_CMD_SRCB];
   wire                        sh2     = cmd_r[`BMPS_CMD_SH2];
   wire                        pair    = cmd_r[`BMPS_CMD_PAIR];
   wire [31:0]                 dsta    = data_r[dst];
   wire [31:0]                 srca    = data_r[src_a];
   wire [31:0]                 srcb    = data_r[src_b];
   wire [31:0]                 pdst    = ptr_r[ptr_ix(dst)];
   wire [31:0]                 psa     = ptr_r[ptr_ix(src_a)];
   wire [31:0]                 psb     = ptr_r[ptr_ix(src_b)];
   wire [31:0]                 cmd_merged = lane_merge({14'h0, cmd_r}, wb_dat_i, wb_sel_i);

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq_o    = irq_r;

   // Byte-lane merge of a bus write into a 32-bit register.
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer      b;
      begin
         lane_merge = old;
         for (b = 0; b < 4; b = b + 1)
         begin
            if (sel[b])
               lane_merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // Pointer index folded into range; callers check validity separately.
   function [2:0] ptr_ix;
      input [2:0] ix;
      begin
         ptr_ix = (ix < `BMPS_NUM_PTR) ? ix : 3'h0;
      end
   endfunction

   function ptr_ok;
      input [2:0] ix;
      begin
         ptr_ok = (ix < `BMPS_NUM_PTR);
      end
   endfunction

   // Bus word decode shared by the read mux and the write path.
   function in_data_bank;
      input [5:0] ix;
      begin
         in_data_bank = (ix < `BMPS_IX_PTR0);
      end
   endfunction

   function in_ptr_bank;
      input [5:0] ix;
      begin
         in_ptr_bank = (ix >= `BMPS_IX_PTR0) && (ix < `BMPS_IX_PTR0 + `BMPS_NUM_PTR);
      end
   endfunction

   function [1:0] shift_dist;
      input s;
      begin
         shift_dist = s ? `BMPS_SHIFT_TWO : `BMPS_SHIFT_ONE;
      end
   endfunction

   function [5:0] ones_count;
      input [31:0] v;
      integer      k;
      begin
         ones_count = 6'h00;
         for (k = 0; k < 32; k = k + 1)
            ones_count = ones_count + {5'h00, v[k]};
      end
   endfunction

   // Operation datapath; every result lands in the register file on the cycle after issue.
   always @*
   begin
      acc_nxt   = first_accumulator_r;
      acc_we    = 1'b0;
      da_we     = 1'b0;
      db_we     = 1'b0;
      p_we      = 1'b0;
      da_ix     = src_a;
      db_ix     = src_b;
      p_ix      = dst;
      da_val    = 32'h0;
      db_val    = 32'h0;
      p_val     = 32'h0;
      flags_nxt = flags_r;
      ev_set    = {`BMPS_STAT_W{1'b0}};
      wide      = {`BMPS_RES_W{1'b0}};
      if (go_r)
      begin
         ev_set[`BMPS_STAT_DONE] = 1'b1;
         case (op)
            `BMPS_OP_NOP:
            begin
               ev_set[`BMPS_STAT_DONE] = 1'b1;
            end
            `BMPS_OP_MUX_RIGHT:
            begin
               acc_nxt = {srcb[0], srca[0], first_accumulator_r[`BMPS_ACC_MSB:2]};
               acc_we  = 1'b1;
               da_we   = 1'b1;
               db_we   = 1'b1;
               da_val  = {1'b0, srca[31:1]};
               db_val  = {1'b0, srcb[31:1]};
            end
            `BMPS_OP_MUX_LEFT:
            begin
               acc_nxt = {first_accumulator_r[`BMPS_ACC_MSB-2:0], srcb[31], srca[31]};
               acc_we  = 1'b1;
               da_we   = 1'b1;
               db_we   = 1'b1;
               da_val  = {srca[30:0], 1'b0};
               db_val  = {srcb[30:0], 1'b0};
            end
            `BMPS_OP_ONES:
            begin
               // Only the destination is written, so a distinct source stays intact.
               da_we  = 1'b1;
               da_ix  = dst;
               da_val = {dsta[31:`BMPS_HALF_W], 10'h000, ones_count(srca)};
            end
            `BMPS_OP_ADDSH_D:
            begin
               if (pair)
                  ev_set[`BMPS_STAT_REFUSED] = 1'b1;
               else
               begin
                  wide = ({{4{dsta[31]}}, dsta} + {{4{srca[31]}}, srca}) << shift_dist(sh2);
                  da_we  = 1'b1;
                  da_ix  = dst;
                  da_val = wide[31:0];
                  flags_nxt[`BMPS_FLAG_ZERO] = (wide[31:0] == 32'h0);
                  flags_nxt[`BMPS_FLAG_NEG]  = wide[31];
                  flags_nxt[`BMPS_FLAG_RANGE] = ~((&wide[35:31]) | ~(|wide[35:31]));
                  if (flags_nxt[`BMPS_FLAG_RANGE])
                  begin
                     flags_nxt[`BMPS_FLAG_STICKY] = 1'b1;
                     ev_set[`BMPS_STAT_OVF]       = 1'b1;
                  end
               end
            end
            `BMPS_OP_ADDSH_P:
            begin
               if (pair || !ptr_ok(dst) || !ptr_ok(src_a))
                  ev_set[`BMPS_STAT_REFUSED] = 1'b1;
               else
               begin
                  p_we  = 1'b1;
                  p_val = (pdst + psa) << shift_dist(sh2);
               end
            end
            `BMPS_OP_SHADD_P:
            begin
               if (pair || !ptr_ok(dst) || !ptr_ok(src_a) || !ptr_ok(src_b))
                  ev_set[`BMPS_STAT_REFUSED] = 1'b1;
               else
               begin
                  p_we  = 1'b1;
                  p_val = psb + (psa << shift_dist(sh2));
               end
            end
            default:
            begin
               ev_set[`BMPS_STAT_REFUSED] = 1'b1;
            end
         endcase
      end
   end

   always @*
   begin
      rd_nxt = 32'h0;
      if (in_data_bank(widx))
         rd_nxt = data_r[widx[2:0]];
      else if (in_ptr_bank(widx))
         rd_nxt = ptr_r[ptr_ix(widx[2:0])];
      else
      begin
         case (widx)
            `BMPS_IX_ACC_LO: rd_nxt = first_accumulator_r[31:0];
            `BMPS_IX_ACC_HI: rd_nxt = {24'h0, first_accumulator_r[`BMPS_ACC_MSB:32]};
            `BMPS_IX_FLAGS:  rd_nxt = {28'h0, flags_r};
            `BMPS_IX_CMD:    rd_nxt = {14'h0, cmd_r};
            `BMPS_IX_STAT:   rd_nxt = {29'h0, stat_r};
            `BMPS_IX_MASK:   rd_nxt = {29'h0, mask_r};
            default:         rd_nxt = 32'h0;
         endcase
      end
   end

   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < `BMPS_NUM_DATA; i = i + 1)
            data_r[i] <= 32'h0;
         for (i = 0; i < `BMPS_NUM_PTR; i = i + 1)
            ptr_r[i] <= 32'h0;
         first_accumulator_r <= 40'h00_0000_0000;
         flags_r             <= 4'h0;
         cmd_r               <= 18'h0_0000;
         go_r                <= 1'b0;
         stat_r              <= 3'h0;
         mask_r              <= 3'h0;
         ack_r               <= 1'b0;
         dat_r               <= 32'h0;
         irq_r               <= 1'b0;
      end
      else
      begin
         ack_r <= bus_req;
         if (bus_req && !wb_we_i)
            dat_r <= rd_nxt;
         go_r <= bus_wr && (widx == `BMPS_IX_CMD) && wb_sel_i[0];
         if (bus_wr)
         begin
            if (in_data_bank(widx))
               data_r[widx[2:0]] <= lane_merge(data_r[widx[2:0]], wb_dat_i, wb_sel_i);
            else if (in_ptr_bank(widx))
               ptr_r[ptr_ix(widx[2:0])] <= lane_merge(ptr_r[ptr_ix(widx[2:0])], wb_dat_i, wb_sel_i);
            else
            begin
               case (widx)
                  `BMPS_IX_ACC_LO:
                     first_accumulator_r[31:0] <= lane_merge(first_accumulator_r[31:0], wb_dat_i, wb_sel_i);
                  `BMPS_IX_ACC_HI:
                     if (wb_sel_i[0])
                        first_accumulator_r[`BMPS_ACC_MSB:32] <= wb_dat_i[7:0];
                  `BMPS_IX_FLAGS:
                     if (wb_sel_i[0])
                        flags_r <= wb_dat_i[`BMPS_FLAG_W-1:0];
                  `BMPS_IX_CMD:
                     cmd_r <= cmd_merged[`BMPS_CMD_W-1:0];
                  `BMPS_IX_MASK:
                     if (wb_sel_i[0])
                        mask_r <= wb_dat_i[`BMPS_STAT_W-1:0];
                  default:
                     mask_r <= mask_r;
               endcase
            end
         end
         // Issue and bus writes never meet: bus_req is masked by ack_r in the cycle after the command write.
         if (acc_we)
            first_accumulator_r <= acc_nxt;
         if (go_r)
            flags_r <= flags_nxt;
         // With identical sources both writes hit one register and the second wins.
         if (da_we)
            data_r[da_ix] <= da_val;
         if (db_we)
            data_r[db_ix] <= db_val;
         if (p_we)
            ptr_r[ptr_ix(p_ix)] <= p_val;
         // A new event wins over a write-one clear in the same cycle.
         if (bus_wr && (widx == `BMPS_IX_STAT) && wb_sel_i[0])
            stat_r <= (stat_r & ~wb_dat_i[`BMPS_STAT_W-1:0]) | ev_set;
         else
            stat_r <= stat_r | ev_set;
         irq_r <= |(stat_r & mask_r);
      end
   end

endmodule

/* File: bmps_core_asserts.sv */
/* Bus, reset and interrupt timing checks for the bit merge datapath.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
module bmps_core_chk (
   input wire        clock,    // core clock
   input wire        rst_n,    // reset, active low
   input wire        wb_cyc_i, // cycle
   input wire        wb_stb_i, // strobe
   input wire        wb_we_i,  // write enable
   input wire [7:0]  wb_adr_i, // byte address
   input wire [3:0]  wb_sel_i, // lane selects
   input wire [31:0] wb_dat_i, // write data
   input wire        wb_ack_o, // acknowledge
   input wire [31:0] wb_dat_o, // read data
   input wire        irq_o     // interrupt
);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire rd  = req && !wb_we_i;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_ack_next: assert property (req |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_rdata_hold: assert property (!rd |=> $stable(wb_dat_o)) else $error("read data moved");
   a_irq_cause: assert property ($changed(irq_o) |-> $past(wb_ack_o, 1) || $past(wb_ack_o, 2)
      || $past(wb_ack_o, 3)) else $error("irq moved without access");
   a_unmap_zero: assert property (rd && wb_adr_i[7:2] > 6'h15 |=> wb_dat_o == 32'h0) else $error("unmapped read");
   a_acc_hi_w: assert property (rd && wb_adr_i[7:2] == 6'h11 |=> wb_dat_o[31:8] == 24'h0) else $error("acc high");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
      else $error("outputs active in reset");
   c_cmd: cover property (req && wb_we_i && wb_adr_i == 8'h4c);
   c_irq: cover property ($rose(irq_o));
   c_unmap: cover property (rd && wb_adr_i[7:2] > 6'h15);
endmodule
bind bmps_core bmps_core_chk chk (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o));

/* File: tb_top.sv */
/* Self-checking bench for bmps_core: merges, ones count, shift-add forms,
   refusals and interrupt. Assumes the design's register map and timing. */
`timescale 1ns/1ps
module tb_top;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [3:0]  lanes = 4'hf;
   wire         ack;
   wire  [31:0] rdat;
   wire         irq;
   int          err_count = 0;
   int          num_checks = 0;
   int          cycles = 0;

   always #2.5 clock = ~clock;

   bmps_core dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .irq_o(irq));

   task results;
   begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   // A hung bus ends here; the run needs well under a thousand cycles.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         results;
      end
   end

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
   begin
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   end
   endtask

   // Ack is read before the edge's own updates land, so it is the sampled value.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
   begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= lanes;
      do @(posedge clock); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      @(posedge clock);
   end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
   begin
      bus(1'b0, a, 32'h0, q);
      chk(n, q, e);
   end
   endtask

   function logic [31:0] cmd(input logic [3:0] op, input logic [2:0] d, input logic [2:0] a,
      input logic [2:0] b, input logic sh2, input logic pair);
      cmd = {14'h0, pair, sh2, 1'b0, b, 1'b0, a, 1'b0, d, op};
   endfunction

   task t_reset;
   begin
      rc(8'h00, 32'h0, "data0");
      rc(8'h44, 32'h0, "acc_hi");
      wr(8'hfc, 32'hffffffff);
      rc(8'hfc, 32'h0, "unmapped");
      lanes = 4'h5;
      wr(8'h00, 32'h11223344);
      lanes = 4'hf;
      rc(8'h00, 32'h00220044, "lane_write");
   end
   endtask

   task t_merge(input logic left);
      logic [39:0] acc;
      logic [31:0] sa;
      logic [31:0] sb;
   begin
      acc = 40'h9a12345678;
      sa = 32'h80000003;
      sb = 32'h40000002;
      wr(8'h04, sa);
      wr(8'h08, sb);
      wr(8'h40, acc[31:0]);
      wr(8'h44, {24'h0, acc[39:32]});
      wr(8'h48, 32'h5);
      wr(8'h4c, cmd(left ? 4'h2 : 4'h1, 3'h0, 3'h1, 3'h2, 1'b0, 1'b1));
      if (left)
      begin
         acc = {acc[37:0], sb[31], sa[31]};
         sa = sa << 1;
         sb = sb << 1;
      end
      else
      begin
         acc = {sb[0], sa[0], acc[39:2]};
         sa = sa >> 1;
         sb = sb >> 1;
      end
      rc(8'h40, acc[31:0], "acc_lo");
      rc(8'h44, {24'h0, acc[39:32]}, "acc_hi");
      rc(8'h04, sa, "source_1");
      rc(8'h08, sb, "source_0");
      rc(8'h48, 32'h5, "merge_flags");
   end
   endtask

   task t_ones;
   begin
      wr(8'h1c, 32'ha5a5a5a5);
      wr(8'h0c, 32'hdeadbeef);
      wr(8'h48, 32'ha);
      wr(8'h4c, cmd(4'h3, 3'h3, 3'h7, 3'h0, 1'b0, 1'b1));
      rc(8'h0c, 32'hdead0010, "ones_dst");
      rc(8'h1c, 32'ha5a5a5a5, "ones_src");
      rc(8'h48, 32'ha, "ones_flags");
      wr(8'h1c, 32'hffffffff);
      wr(8'h4c, cmd(4'h3, 3'h7, 3'h7, 3'h0, 1'b0, 1'b0));
      rc(8'h1c, 32'hffff0020, "ones_full");
   end
   endtask

   task t_addsh_data;
   begin
      wr(8'h48, 32'h0);
      wr(8'h10, 32'h30000000);
      wr(8'h14, 32'h10000000);
      wr(8'h4c, cmd(4'h4, 3'h4, 3'h5, 3'h0, 1'b0, 1'b0));
      rc(8'h10, 32'h80000000, "addsh_ovf");
      rc(8'h48, 32'he, "flags_ovf");
      rc(8'h50, 32'h5, "stat_ovf");
      wr(8'h14, 32'h80000000);
      wr(8'h4c, cmd(4'h4, 3'h4, 3'h5, 3'h0, 1'b1, 1'b0));
      rc(8'h10, 32'h0, "addsh_wrap");
      rc(8'h48, 32'hd, "flags_zero");
      wr(8'h14, 32'h10000000);
      wr(8'h4c, cmd(4'h4, 3'h4, 3'h5, 3'h0, 1'b1, 1'b0));
      rc(8'h10, 32'h40000000, "addsh_x4");
      rc(8'h48, 32'h8, "flags_sticky");
   end
   endtask

   task t_ptr;
   begin
      wr(8'h48, 32'h5);
      wr(8'h24, 32'hc0000001);
      wr(8'h28, 32'h1);
      wr(8'h4c, cmd(4'h5, 3'h1, 3'h2, 3'h0, 1'b1, 1'b0));
      rc(8'h24, 32'h8, "addsh_ptr");
      wr(8'h2c, 32'h10);
      wr(8'h20, 32'h3);
      wr(8'h4c, cmd(4'h6, 3'h3, 3'h3, 3'h0, 1'b0, 1'b0));
      rc(8'h2c, 32'h23, "shadd_x2");
      wr(8'h4c, cmd(4'h6, 3'h3, 3'h3, 3'h0, 1'b1, 1'b0));
      rc(8'h2c, 32'h8f, "shadd_x4");
      rc(8'h48, 32'h5, "ptr_flags");
   end
   endtask

   task t_refuse_irq;
   begin
      wr(8'h14, 32'h11);
      wr(8'h54, 32'h2);
      for (int op = 4; op <= 7; op++)
      begin
         wr(8'h50, 32'h7);
         wr(8'h4c, cmd(op[3:0], 3'h5, 3'h5, 3'h5, 1'b0, 1'b1));
         rc(8'h50, 32'h3, "stat_refused");
         chk("irq_set", {31'h0, irq}, 32'h1);
         wr(8'h50, 32'h2);
         rc(8'h14, 32'h11, "refused_dst");
         chk("irq_clear", {31'h0, irq}, 32'h0);
      end
      wr(8'h50, 32'h7);
      wr(8'h4c, cmd(4'h5, 3'h6, 3'h6, 3'h0, 1'b0, 1'b0));
      rc(8'h50, 32'h3, "stat_bad_ptr");
      wr(8'h50, 32'h7);
      wr(8'h4c, cmd(4'h0, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0));
      rc(8'h50, 32'h1, "stat_nop");
      rc(8'h34, 32'h0, "refused_ptr");
      wr(8'h54, 32'h0);
      wr(8'h4c, cmd(4'h4, 3'h5, 3'h5, 3'h5, 1'b0, 1'b1));
      rc(8'h50, 32'h3, "stat_masked");
      chk("irq_masked", {31'h0, irq}, 32'h0);
   end
   endtask

   initial
   begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset;
      t_merge(1'b0);
      t_merge(1'b1);
      t_ones;
      t_addsh_data;
      t_ptr;
      t_refuse_irq;
      results;
   end
endmodule
